//--- core/pma_pkg.sv
// ************************************************************
// Shared constants for the math accelerator
// ************************************************************
package pma_pkg;
    localparam int OP_W = 16;
    localparam int ERR_W = 17;
    localparam int EXT_W = 18;
    localparam int PROD_W = 36;
    localparam int ACC_W = 35;
    localparam int WORK_W = 38;
    localparam int BYTE_W = 8;
    localparam int BUSY_MAX = 4;

    localparam logic [2:0] MODE_UNS = 3'h0;
    localparam logic [2:0] MODE_UNS_ACC = 3'h1;
    localparam logic [2:0] MODE_SGN = 3'h2;
    localparam logic [2:0] MODE_SGN_ACC = 3'h3;
    localparam logic [2:0] MODE_CTL = 3'h5;

    localparam logic [ACC_W-1:0] RESULT_RST = 35'h0_0000_0000;
    localparam logic [ERR_W-1:0] ERR_RST = 17'h0_0000;
    localparam logic [OP_W-1:0] OP_RST = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_P1 = 5'b0_0010,
        ST_P2 = 5'b0_0100,
        ST_P3 = 5'b0_1000,
        ST_FIN = 5'b1_0000
    } pma_state_t;
endpackage : pma_pkg

//--- core/pma_mul.sv
`timescale 1ns/100ps
// ************************************************************
// Registered signed multiplier, one cycle of latency
// ************************************************************
module pma_mul #(
    parameter int IN_W = 18
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic signed [IN_W-1:0] a_in,
    input wire logic signed [IN_W-1:0] b_in,
    output logic signed [2*IN_W-1:0] prod_out
);
    logic signed [2*IN_W-1:0] prod_d;

    always_comb
    begin
        prod_d = prod_out;
        if (ce_in)
        begin
            prod_d = a_in * b_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            prod_out <= '0;
        end
        else
        begin
            prod_out <= prod_d;
        end
    end
endmodule : pma_mul

//--- core/pma_accel.sv
`timescale 1ns/100ps
// Overview of operation
// - Mode 101 selects three-term controller operation
// - Error equals set point minus input sample
// - Sum error products with three coefficients
// - Shift previous into oldest, current into previous
// - Controller mode accumulates results into output
// - Low input byte write starts, sets busy
// - Busy stays high until computation ends
// - Restored output and errors resume computation
// - Modes 000-011 compute (input+setpoint)*first coefficient
// - Modes select signedness and accumulation
// - Accumulating modes add; others replace output
// - Operands are sixteen bits wide
// - Completion flag sets as busy falls
// - Overflow wraps and sets overflow flag
// - Interrupt only for enabled flags
module pma_accel (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic module_enable_in,
    input wire logic [2:0] operating_mode_in,
    input wire logic [pma_pkg::OP_W-1:0] setpoint_value_in,
    input wire logic [pma_pkg::OP_W-1:0] coeff_current_in,
    input wire logic [pma_pkg::OP_W-1:0] coeff_previous_in,
    input wire logic [pma_pkg::OP_W-1:0] coeff_oldest_in,
    input wire logic input_sample_high_wr_in,
    input wire logic input_sample_low_wr_in,
    input wire logic [pma_pkg::BYTE_W-1:0] input_byte_in,
    input wire logic result_output_wr_in,
    input wire logic [pma_pkg::ACC_W-1:0] result_output_data_in,
    input wire logic previous_error_wr_in,
    input wire logic oldest_error_wr_in,
    input wire logic [pma_pkg::ERR_W-1:0] error_data_in,
    input wire logic completion_irq_enable_in,
    input wire logic overflow_irq_enable_in,
    input wire logic completion_irq_clear_in,
    input wire logic overflow_irq_clear_in,
    output logic busy_out,
    output logic [pma_pkg::ACC_W-1:0] result_output_reg_out,
    output logic [pma_pkg::ERR_W-1:0] previous_error_reg_out,
    output logic [pma_pkg::ERR_W-1:0] oldest_error_reg_out,
    output logic completion_irq_flag_out,
    output logic overflow_irq_flag_out,
    output logic irq_out
);
    // ************************************************************
    // State
    // ************************************************************
    pma_pkg::pma_state_t state_q, state_d;
    logic [2:0] mode_q, mode_d;
    logic [pma_pkg::BYTE_W-1:0] in_hi_q, in_hi_d;
    logic [pma_pkg::OP_W-1:0] in_q, in_d, set_q, set_d;
    logic [pma_pkg::OP_W-1:0] k1_q, k1_d, k2_q, k2_d, k3_q, k3_d;
    logic [pma_pkg::ERR_W-1:0] err_q, err_d, prev_q, prev_d;
    logic [pma_pkg::ERR_W-1:0] old_q, old_d;
    logic signed [pma_pkg::WORK_W-1:0] acc_q, acc_d;
    logic [pma_pkg::ACC_W-1:0] result_q, result_d;
    logic busy_q, busy_d, done_q, done_d, ovf_q, ovf_d, irq_q, irq_d;

    logic start;
    logic fin;
    logic ctl_mode;
    logic sgn_mode;
    logic acc_mode;
    logic ovf_now;
    logic [pma_pkg::OP_W-1:0] sample;
    logic [pma_pkg::EXT_W-1:0] ab_sum;
    logic signed [pma_pkg::EXT_W-1:0] mul_a, mul_b;
    logic signed [pma_pkg::PROD_W-1:0] prod;
    logic signed [pma_pkg::WORK_W-1:0] prod_ext, acc_fin, res_ext;

    assign busy_out = busy_q;
    assign result_output_reg_out = result_q;
    assign previous_error_reg_out = prev_q;
    assign oldest_error_reg_out = old_q;
    assign completion_irq_flag_out = done_q;
    assign overflow_irq_flag_out = ovf_q;
    assign irq_out = irq_q;

    // ************************************************************
    // Multiplier
    // ************************************************************
    pma_mul #(
        .IN_W(pma_pkg::EXT_W)
    ) u_mul (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .a_in(mul_a),
        .b_in(mul_b),
        .prod_out(prod)
    );

    // ************************************************************
    // Operand steering
    // ************************************************************
    always_comb
    begin
        ctl_mode = (mode_q == pma_pkg::MODE_CTL);
        sgn_mode = (mode_q == pma_pkg::MODE_SGN)
            || (mode_q == pma_pkg::MODE_SGN_ACC) || ctl_mode;
        // 18-bit sum of 16-bit operands extended by the mode's signedness
        if (sgn_mode)
        begin
            ab_sum = {{2{in_q[15]}}, in_q} + {{2{set_q[15]}}, set_q};
        end
        else
        begin
            ab_sum = {2'h0, in_q} + {2'h0, set_q};
        end
        mul_a = '0;
        mul_b = '0;
        case (state_q)
            pma_pkg::ST_P1:
            begin
                if (ctl_mode)
                begin
                    mul_a = {err_q[16], err_q};
                end
                else
                begin
                    mul_a = ab_sum;
                end
                mul_b = sgn_mode ? {{2{k1_q[15]}}, k1_q} : {2'h0, k1_q};
            end
            pma_pkg::ST_P2:
            begin
                mul_a = {prev_q[16], prev_q};
                mul_b = {{2{k2_q[15]}}, k2_q};
            end
            pma_pkg::ST_P3:
            begin
                mul_a = {old_q[16], old_q};
                mul_b = {{2{k3_q[15]}}, k3_q};
            end
            default:
            begin
                mul_a = '0;
                mul_b = '0;
            end
        endcase
    end

    // ************************************************************
    // Sequencer and datapath next state
    // ************************************************************
    always_comb
    begin
        sample = {in_hi_q, input_byte_in};
        // Disabled block drops the trigger entirely
        start = input_sample_low_wr_in && module_enable_in
            && !busy_q;
        fin = (state_q == pma_pkg::ST_FIN);
        acc_mode = (operating_mode_in == pma_pkg::MODE_UNS_ACC)
            || (operating_mode_in == pma_pkg::MODE_SGN_ACC)
            || (operating_mode_in == pma_pkg::MODE_CTL);
        prod_ext = {{2{prod[35]}}, prod};
        acc_fin = acc_q + prod_ext;
        if (sgn_mode)
        begin
            ovf_now = (acc_fin[37:34] != 4'h0)
                && (acc_fin[37:34] != 4'hf);
        end
        else
        begin
            ovf_now = (acc_fin[37:35] != 3'h0);
        end
        if ((operating_mode_in == pma_pkg::MODE_UNS)
            || (operating_mode_in == pma_pkg::MODE_UNS_ACC))
        begin
            res_ext = {3'h0, result_q};
        end
        else
        begin
            res_ext = {{3{result_q[34]}}, result_q};
        end

        state_d = state_q;
        mode_d = mode_q;
        in_hi_d = in_hi_q;
        in_d = in_q;
        set_d = set_q;
        k1_d = k1_q;
        k2_d = k2_q;
        k3_d = k3_q;
        err_d = err_q;
        prev_d = prev_q;
        old_d = old_q;
        acc_d = acc_q;
        result_d = result_q;
        busy_d = busy_q;
        done_d = done_q && !completion_irq_clear_in;
        ovf_d = ovf_q && !overflow_irq_clear_in;

        if (input_sample_high_wr_in && !busy_q)
        begin
            in_hi_d = input_byte_in;
        end
        if (!busy_q)
        begin
            // Restored context takes effect at the next start
            if (result_output_wr_in)
            begin
                result_d = result_output_data_in;
                res_ext = {{3{result_output_data_in[34]}},
                    result_output_data_in};
                if ((operating_mode_in == pma_pkg::MODE_UNS)
                    || (operating_mode_in == pma_pkg::MODE_UNS_ACC))
                begin
                    res_ext = {3'h0, result_output_data_in};
                end
            end
            if (previous_error_wr_in)
            begin
                prev_d = error_data_in;
            end
            if (oldest_error_wr_in)
            begin
                old_d = error_data_in;
            end
        end

        case (state_q)
            pma_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    state_d = pma_pkg::ST_P1;
                    busy_d = 1'b1;
                    mode_d = operating_mode_in;
                    in_d = sample;
                    set_d = setpoint_value_in;
                    k1_d = coeff_current_in;
                    k2_d = coeff_previous_in;
                    k3_d = coeff_oldest_in;
                    err_d = {setpoint_value_in[15], setpoint_value_in}
                        - {sample[15], sample};
                    acc_d = acc_mode ? res_ext : '0;
                end
            end
            pma_pkg::ST_P1:
            begin
                state_d = ctl_mode ? pma_pkg::ST_P2 : pma_pkg::ST_FIN;
            end
            pma_pkg::ST_P2:
            begin
                acc_d = acc_q + prod_ext;
                state_d = pma_pkg::ST_P3;
            end
            pma_pkg::ST_P3:
            begin
                acc_d = acc_q + prod_ext;
                state_d = pma_pkg::ST_FIN;
            end
            pma_pkg::ST_FIN:
            begin
                // Wider work sum lets the wrap be seen before truncation
                result_d = acc_fin[pma_pkg::ACC_W-1:0];
                acc_d = acc_fin;
                busy_d = 1'b0;
                done_d = 1'b1;
                if (ovf_now)
                begin
                    ovf_d = 1'b1;
                end
                if (ctl_mode)
                begin
                    old_d = prev_q;
                    prev_d = err_q;
                end
                state_d = pma_pkg::ST_IDLE;
            end
            default:
            begin
                state_d = pma_pkg::ST_IDLE;
                busy_d = 1'b0;
            end
        endcase
        irq_d = (done_d && completion_irq_enable_in)
            || (ovf_d && overflow_irq_enable_in);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= pma_pkg::ST_IDLE;
            mode_q <= pma_pkg::MODE_UNS;
            in_hi_q <= '0;
            in_q <= pma_pkg::OP_RST;
            set_q <= pma_pkg::OP_RST;
            k1_q <= pma_pkg::OP_RST;
            k2_q <= pma_pkg::OP_RST;
            k3_q <= pma_pkg::OP_RST;
            err_q <= pma_pkg::ERR_RST;
            prev_q <= pma_pkg::ERR_RST;
            old_q <= pma_pkg::ERR_RST;
            acc_q <= '0;
            result_q <= pma_pkg::RESULT_RST;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            ovf_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (ce_in)
        begin
            state_q <= state_d;
            mode_q <= mode_d;
            in_hi_q <= in_hi_d;
            in_q <= in_d;
            set_q <= set_d;
            k1_q <= k1_d;
            k2_q <= k2_d;
            k3_q <= k3_d;
            err_q <= err_d;
            prev_q <= prev_d;
            old_q <= old_d;
            acc_q <= acc_d;
            result_q <= result_d;
            busy_q <= busy_d;
            done_q <= done_d;
            ovf_q <= ovf_d;
            irq_q <= irq_d;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [3:0] busy_cnt_q;
    logic signed [pma_pkg::PROD_W-1:0] chk_prod;

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in || !busy_q)
        begin
            busy_cnt_q <= '0;
        end
        else if (ce_in && busy_cnt_q != 4'hf)
        begin
            busy_cnt_q <= busy_cnt_q + 4'h1;
        end
    end

    always_comb
    begin
        chk_prod = $signed(ab_sum) * (sgn_mode
            ? $signed({{2{k1_q[15]}}, k1_q})
            : $signed({2'h0, k1_q}));
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_start;
        ce_in && start;
    endsequence

    sequence s_fin_ctl;
        ce_in && fin && ctl_mode;
    endsequence

    a_start_sets_busy: assert property (s_start |=> busy_q)
        else $error("busy not set by start");
    a_disabled_no_start: assert property (
        ce_in && input_sample_low_wr_in && !module_enable_in && !busy_q
        |=> !busy_q)
        else $error("disabled block started");
    a_busy_bounded: assert property (
        busy_cnt_q <= 4'(pma_pkg::BUSY_MAX))
        else $error("busy held too long");
    a_done_at_fall: assert property (
        $fell(busy_q) |-> completion_irq_flag_out)
        else $error("completion flag missing at busy fall");
    a_error_shift: assert property (s_fin_ctl |=>
        prev_q == $past(err_q) && old_q == $past(prev_q))
        else $error("error history not shifted");
    a_ctl_error: assert property (
        (s_start and (operating_mode_in == pma_pkg::MODE_CTL))
        |=> err_q == {set_q[15], set_q} - {in_q[15], in_q})
        else $error("controller error wrong");
    a_nonacc_result: assert property (
        ce_in && state_q == pma_pkg::ST_P1 && !ctl_mode
        && (mode_q == pma_pkg::MODE_UNS || mode_q == pma_pkg::MODE_SGN)
        ##1 ce_in
        |=> result_q == chk_prod[pma_pkg::ACC_W-1:0])
        else $error("add and multiply result wrong");
    a_ovf_flag: assert property (
        ce_in && fin && ovf_now |=> overflow_irq_flag_out)
        else $error("overflow flag not set");
    a_irq_gating: assert property (
        ce_in && !completion_irq_enable_in && !overflow_irq_enable_in
        |=> !irq_out)
        else $error("interrupt without enable");
endmodule : pma_accel

//--- bench/tb.sv
`timescale 1ns/100ps
// ************************************************************
// Self-checking bench for the math accelerator
// ************************************************************
module tb;
    logic clk_sys_in;
    logic rst_n_in;
    logic ce_in;
    logic en;
    logic [2:0] mode;
    logic [15:0] set_v;
    logic [15:0] k1;
    logic [15:0] k2;
    logic [15:0] k3;
    logic hi_wr;
    logic lo_wr;
    logic [7:0] byte_v;
    logic out_wr;
    logic [34:0] out_data;
    logic prev_wr;
    logic old_wr;
    logic [16:0] err_data;
    logic cie;
    logic oie;
    logic cclr;
    logic oclr;
    logic busy;
    logic [34:0] res;
    logic [16:0] prev;
    logic [16:0] old;
    logic cflag;
    logic oflag;
    logic irq;
    int n_mismatch;
    int n_compared;
    int cycles;
    // Reference copies of the state the block should hold
    logic signed [34:0] m_out;
    logic signed [16:0] m_prev;
    logic signed [16:0] m_old;

    pma_accel i_pma_accel (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .module_enable_in(en), .operating_mode_in(mode),
        .setpoint_value_in(set_v), .coeff_current_in(k1),
        .coeff_previous_in(k2), .coeff_oldest_in(k3),
        .input_sample_high_wr_in(hi_wr), .input_sample_low_wr_in(lo_wr),
        .input_byte_in(byte_v), .result_output_wr_in(out_wr),
        .result_output_data_in(out_data), .previous_error_wr_in(prev_wr),
        .oldest_error_wr_in(old_wr), .error_data_in(err_data),
        .completion_irq_enable_in(cie), .overflow_irq_enable_in(oie),
        .completion_irq_clear_in(cclr), .overflow_irq_clear_in(oclr),
        .busy_out(busy), .result_output_reg_out(res),
        .previous_error_reg_out(prev), .oldest_error_reg_out(old),
        .completion_irq_flag_out(cflag), .overflow_irq_flag_out(oflag),
        .irq_out(irq)
    );

    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task results;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            results();
        end
    end

    task chk(input string what, input logic [63:0] exp, got);
        n_compared++;
        if (exp !== got)
        begin
            n_mismatch++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : chk

    // High byte first, low byte starts the work
    task start(input logic [15:0] smp, input int exp_n, input logic exp_irq);
        int n;
        @(posedge clk_sys_in);
        hi_wr <= 1'b1;
        byte_v <= smp[15:8];
        @(posedge clk_sys_in);
        hi_wr <= 1'b0;
        lo_wr <= 1'b1;
        byte_v <= smp[7:0];
        @(posedge clk_sys_in);
        lo_wr <= 1'b0;
        #1;
        chk("busy after start", 1, busy);
        n = 0;
        while (busy === 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_sys_in);
            #1;
        end
        chk("busy cycles", exp_n, n);
        chk("completion flag", 1, cflag);
        chk("result", m_out[34:0], res);
        @(posedge clk_sys_in);
        cclr <= 1'b1;
        #1;
        chk("irq", exp_irq, irq);
        @(posedge clk_sys_in);
        cclr <= 1'b0;
        #1;
        chk("completion cleared", 0, cflag);
    endtask : start

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_reset;
        chk("busy reset", 0, busy);
        chk("result reset", 0, res);
        chk("flags reset", 0, {cflag, oflag, irq});
    endtask : t_reset

    task t_disabled;
        @(posedge clk_sys_in);
        en <= 1'b0;
        lo_wr <= 1'b1;
        @(posedge clk_sys_in);
        lo_wr <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk("busy disabled", 0, busy);
        chk("flag disabled", 0, cflag);
    endtask : t_disabled

    // Every add-and-multiply mode, one negative input
    task t_mac;
        logic [36:0] a;
        logic [36:0] k;
        logic [36:0] p;
        m_out = '0;
        set_v <= 16'h0020;
        k1 <= 16'hFFFD;
        for (int md = 0; md < 4; md++)
        begin
            @(posedge clk_sys_in);
            en <= 1'b0;
            mode <= md[2:0];
            @(posedge clk_sys_in);
            en <= 1'b1;
            cie <= md[0];
            #1;
            if (md[1])
            begin
                a = {{21{1'b1}}, 16'hFFF0} + {21'h0_0000, set_v};
                k = {{21{k1[15]}}, k1};
            end
            else
            begin
                a = {21'h0_0000, 16'hFFF0} + {21'h0_0000, set_v};
                k = {21'h0_0000, k1};
            end
            p = a * k;
            m_out = md[0] ? m_out + p[34:0] : p[34:0];
            start(16'hFFF0, 2, md[0]);
            chk("no overflow", 0, oflag);
        end
    endtask : t_mac

    task ctl_step(input logic [15:0] smp);
        logic signed [16:0] e;
        e = $signed({set_v[15], set_v}) - $signed({smp[15], smp});
        m_out = m_out + $signed(k1) * e + $signed(k2) * m_prev
            + $signed(k3) * m_old;
        m_old = m_prev;
        m_prev = e;
        start(smp, 4, 1'b1);
        chk("previous error", m_prev[16:0], prev);
        chk("oldest error", m_old[16:0], old);
    endtask : ctl_step

    task t_ctl;
        @(posedge clk_sys_in);
        en <= 1'b0;
        mode <= pma_pkg::MODE_CTL;
        @(posedge clk_sys_in);
        en <= 1'b1;
        cie <= 1'b1;
        k1 <= 16'h0002;
        k2 <= 16'hFFFF;
        k3 <= 16'h0003;
        set_v <= 16'h0064;
        out_wr <= 1'b1;
        out_data <= 35'h0_0000_0000;
        prev_wr <= 1'b1;
        old_wr <= 1'b1;
        err_data <= 17'h0_0000;
        @(posedge clk_sys_in);
        {out_wr, prev_wr, old_wr} <= 3'h0;
        m_out = '0;
        m_prev = '0;
        m_old = '0;
        ctl_step(16'h0028);
        ctl_step(16'h0046);
        ctl_step(16'h00A0);
    endtask : t_ctl

    // Restore a saved context, then resume
    task t_restore;
        @(posedge clk_sys_in);
        out_wr <= 1'b1;
        out_data <= 35'h0_0000_0010;
        prev_wr <= 1'b1;
        old_wr <= 1'b1;
        err_data <= 17'h1_FFFF;
        @(posedge clk_sys_in);
        {out_wr, prev_wr, old_wr} <= 3'h0;
        #1;
        chk("restored output", 35'h0_0000_0010, res);
        m_out = 35'h0_0000_0010;
        m_prev = -17'sd1;
        m_old = -17'sd1;
        ctl_step(16'h0010);
    endtask : t_restore

    // Unsigned accumulation past the top wraps and flags
    task t_overflow;
        @(posedge clk_sys_in);
        en <= 1'b0;
        mode <= pma_pkg::MODE_UNS_ACC;
        @(posedge clk_sys_in);
        en <= 1'b1;
        cie <= 1'b0;
        oie <= 1'b1;
        set_v <= 16'h0000;
        k1 <= 16'h0001;
        out_wr <= 1'b1;
        out_data <= 35'h7_FFFF_FFFF;
        @(posedge clk_sys_in);
        out_wr <= 1'b0;
        m_out = 35'h0_0000_0001;
        start(16'h0002, 2, 1'b1);
        chk("overflow flag", 1, oflag);
        // Saturate and clear, as a handler would
        @(posedge clk_sys_in);
        out_wr <= 1'b1;
        out_data <= 35'h7_FFFF_FFFF;
        oclr <= 1'b1;
        @(posedge clk_sys_in);
        out_wr <= 1'b0;
        oclr <= 1'b0;
        #1;
        chk("saturated output", 35'h7_FFFF_FFFF, res);
        chk("overflow cleared", 0, oflag);
    endtask : t_overflow

    initial
    begin
        n_mismatch = 0;
        n_compared = 0;
        cycles = 0;
        rst_n_in = 1'b0;
        ce_in = 1'b1;
        en = 1'b0;
        mode = 3'h0;
        {set_v, k1, k2, k3} = 64'h0000_0000_0000_0000;
        {hi_wr, lo_wr, out_wr, prev_wr, old_wr} = 5'h00;
        byte_v = 8'h00;
        out_data = 35'h0_0000_0000;
        err_data = 17'h0_0000;
        {cie, oie, cclr, oclr} = 4'h0;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        #1;
        t_reset();
        t_disabled();
        t_mac();
        t_ctl();
        t_restore();
        t_overflow();
        results();
    end
endmodule : tb
